// ==== verilog/overrange_and_timestamp_marker.sv ====
// Behaviour
// RULE1: Capture each sample on rising clock edge.
// RULE2: Samples are signed codes -256 to 255.
// RULE3: Detector runs only when enable is 1.
// RULE4: 8-bit magnitude compared against 8-bit threshold.
// RULE5: Magnitude: +255,-256 give 255; zero 0.
// RULE6: Over-range bit high when magnitude reaches threshold.
// RULE7: One dedicated over-range pin per channel.
// RULE8: Hold output 8 times 2^select cycles.
// RULE9: Software should set threshold near 228.
// RULE10: Downstream lowers gain, restores after clearing.
// RULE11: Retime stamp; repeat when enabled, mode 3.
// RULE12: Stamp input asynchronous, sampled like data.
// RULE13: Stamp latency equals data sample latency.
// RULE14: Stamp replaces link word LSB when inserting.
// RULE15: Mode 0: 12-bit word, stamp bit 0.
// RULE16: Stamp receiver must be enabled before use.
// RULE17: Disabled detector holds outputs low, counters clear.
`timescale 1ns/100ps
`default_nettype none
module overrange_and_timestamp_marker
  import ovr_stamp_pkg::*;
#(
  parameter int ACTIVE_CHANNELS = 4
) (
  // Clocking
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clockEnable,
  // Converted samples
  input wire logic sampleValid,
  output logic sampleReady,
  input wire sample_set_s samples,
  // Timestamp pin, already made single ended
  input wire logic stamp_input_pair,
  // Over-range settings
  input wire logic overrange_detect_enable,
  input wire logic [SEL_W-1:0] overrange_hold_select,
  input wire logic [MAG_W-1:0] overrange_threshold,
  // Timestamp settings
  input wire logic stamp_receiver_enable,
  input wire logic stampInsertEnable,
  input wire logic trigger_repeat_enable,
  input wire logic [1:0] trigger_repeat_select,
  input wire logic [1:0] link_format_select,
  // Over-range pins
  output logic overrange_out_a,
  output logic overrange_out_b,
  output logic overrange_out_c,
  output logic overrange_out_d,
  // Trigger repeat pin
  output logic trigger_repeat_out,
  // Link stream
  output logic linkValid,
  input wire logic linkReady,
  output link_frame_s linkFrame,
  // Status
  input wire logic statusClear,
  output logic [CHANNELS-1:0] overrangeSeen,
  output logic sampleDropped,
  output logic [STAMP_CNT_W-1:0] stampCount
);
  sample_set_s captured;
  logic capturedValid;
  sample_set_s alignPipe [ALIGN_STAGES];
  logic alignValid [ALIGN_STAGES];
  logic stampMeta;
  logic stampSync;
  logic stampPrev;
  logic stampRise;
  logic stampLive;
  ovr_cfg_s ovrCfg;
  stamp_cfg_s stampCfg;
  logic [CHANNELS-1:0] chanEvent;
  logic [CHANNELS-1:0] chanOver;
  logic [CHANNELS-1:0] chanActive;
  link_frame_s frame;
  logic frameValid;
  logic fifoInReady;

  assign ovrCfg = '{enable: overrange_detect_enable,
                    holdSelect: overrange_hold_select,
                    threshold: overrange_threshold};

  assign stampCfg = '{receiverEnable: stamp_receiver_enable,
                      insertEnable: stampInsertEnable,
                      repeatEnable: trigger_repeat_enable,
                      repeatSelect: trigger_repeat_select};

  // Channels beyond the fitted count stay silent
  function automatic logic [CHANNELS-1:0] activeMask(input int n);
    logic [CHANNELS-1:0] m;
    m = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (i < n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  assign chanActive = activeMask(ACTIVE_CHANNELS);

  // Place a sample left justified in the word, stamp in bit 0
  function automatic link_word_t linkWord(input link_mode_e mode,
                                          input sample_t s,
                                          input logic stamp,
                                          input logic insert);
    link_word_t w;
    w = '0;
    case (mode)
      LINK_N8: begin
        w[N8_MSB:0] = s[SAMPLE_W-1:1];
      end
      LINK_N16: begin
        w[N16_MSB -: SAMPLE_W] = s;
      end
      default: begin
        w[N12_MSB -: SAMPLE_W] = s; // RULE15
      end
    endcase
    if (insert) begin
      w[0] = stamp; // RULE14
    end
    return w;
  endfunction

  // Sample capture; the source sees back-pressure through sampleReady
  assign sampleReady = fifoInReady;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      captured <= '0;
      capturedValid <= 1'b0;
    end else if (clockEnable) begin
      captured <= samples; // RULE1 RULE2
      capturedValid <= sampleValid;
    end
  end

  // Data waits for the stamp synchroniser
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < ALIGN_STAGES; i++) begin
        alignPipe[i] <= '0;
        alignValid[i] <= 1'b0;
      end
    end else if (clockEnable) begin
      alignPipe[0] <= captured; // RULE13
      alignValid[0] <= capturedValid;
      for (int i = 1; i < ALIGN_STAGES; i++) begin
        alignPipe[i] <= alignPipe[i-1];
        alignValid[i] <= alignValid[i-1];
      end
    end
  end

  // Stamp pin is asynchronous; two flops before any use
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stampMeta <= 1'b0;
      stampSync <= 1'b0;
    end else if (clockEnable) begin
      stampMeta <= stamp_input_pair; // RULE12
      stampSync <= stampMeta; // RULE11
    end
  end

  // Receiver off means no mark is ever produced
  assign stampLive = stampCfg.receiverEnable && stampSync; // RULE16

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stampPrev <= 1'b0;
    end else if (clockEnable) begin
      stampPrev <= stampLive;
    end
  end

  assign stampRise = stampLive && !stampPrev;

  // Counts trigger edges so software can match marks
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stampCount <= '0;
    end else if (clockEnable && stampRise) begin
      stampCount <= stampCount + 1'b1;
    end
  end

  // Trigger repeat only in the stamp mode
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      trigger_repeat_out <= 1'b0;
    end else if (clockEnable) begin
      trigger_repeat_out <= stampCfg.repeatEnable &&
                            (stampCfg.repeatSelect == TRIG_MODE_STAMP) &&
                            stampLive; // RULE11
    end
  end

  // Per channel over-range detection on captured samples
  for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
    overrange_hold u_hold (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .clockEnable(clockEnable),
      .sample(captured.ch[c]),
      .cfg(ovrCfg),
      .eventHit(chanEvent[c]),
      .overrange(chanOver[c])
    );
  end

  // Dedicated pins, one per channel
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      overrange_out_a <= 1'b0;
      overrange_out_b <= 1'b0;
      overrange_out_c <= 1'b0;
      overrange_out_d <= 1'b0;
    end else if (clockEnable) begin
      overrange_out_a <= chanOver[0] && chanActive[0]; // RULE7
      overrange_out_b <= chanOver[1] && chanActive[1]; // RULE7
      overrange_out_c <= chanOver[2] && chanActive[2]; // RULE7
      overrange_out_d <= chanOver[3] && chanActive[3]; // RULE7
    end
  end

  // Sticky record of events; a new event beats a clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      overrangeSeen <= '0;
    end else if (clockEnable) begin
      overrangeSeen <= ((statusClear ? '0 : overrangeSeen) |
                        (chanEvent & chanActive & {CHANNELS{capturedValid}}));
    end
  end

  // Link frame build: sample and stamp meet in the same word
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      frame <= '0;
      frameValid <= 1'b0;
    end else if (clockEnable) begin
      frameValid <= alignValid[ALIGN_STAGES-1];
      for (int c = 0; c < CHANNELS; c++) begin
        frame.word[c] <= chanActive[c] ?
                         linkWord(link_mode_e'(link_format_select),
                                  alignPipe[ALIGN_STAGES-1].ch[c],
                                  stampLive,
                                  stampCfg.insertEnable) : '0; // RULE13 RULE14
      end
    end
  end

  // A full buffer loses a frame; flagged so software knows
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sampleDropped <= 1'b0;
    end else if (clockEnable) begin
      sampleDropped <= (statusClear ? 1'b0 : sampleDropped) |
                       (frameValid && !fifoInReady);
    end
  end

  sample_fifo #(
    .WIDTH($bits(link_frame_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clockEnable(clockEnable),
    .inValid(frameValid),
    .inReady(fifoInReady),
    .inData(frame),
    .outValid(linkValid),
    .outReady(linkReady),
    .outData(linkFrame)
  );
endmodule // overrange_and_timestamp_marker
`default_nettype wire

// ==== verilog/ovr_stamp_pkg.sv ====
package ovr_stamp_pkg;
  localparam int SAMPLE_W = 9;
  localparam int MAG_W = 8;
  localparam int CHANNELS = 4;
  localparam int LINK_W = 16;
  localparam int FIFO_DEPTH = 32;
  localparam int HOLD_W = 11;
  localparam int SEL_W = 3;
  localparam int SYNC_STAGES = 2;
  localparam int ALIGN_STAGES = SYNC_STAGES - 1;
  localparam int STAMP_CNT_W = 16;
  localparam logic [HOLD_W-1:0] HOLD_BASE = 11'h008;
  localparam logic [MAG_W-1:0] MAG_MAX = 8'hff;
  localparam logic [MAG_W-1:0] THRESHOLD_RESET = 8'he4;
  localparam logic [1:0] TRIG_MODE_STAMP = 2'h3;
  localparam int N12_MSB = 11;
  localparam int N8_MSB = 7;
  localparam int N16_MSB = 15;

  typedef logic signed [SAMPLE_W-1:0] sample_t;
  typedef logic [LINK_W-1:0] link_word_t;

  typedef enum logic [1:0] {LINK_N12, LINK_N8, LINK_N16, LINK_SPARE} link_mode_e;

  typedef struct packed {
    logic enable;
    logic [SEL_W-1:0] holdSelect;
    logic [MAG_W-1:0] threshold;
  } ovr_cfg_s;

  typedef struct packed {
    logic receiverEnable;
    logic insertEnable;
    logic repeatEnable;
    logic [1:0] repeatSelect;
  } stamp_cfg_s;

  typedef struct packed {
    sample_t [CHANNELS-1:0] ch;
  } sample_set_s;

  typedef struct packed {
    link_word_t [CHANNELS-1:0] word;
  } link_frame_s;
endpackage

// ==== verilog/sample_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  // Clocking
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clockEnable,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign inReady = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge ref_clk) begin
    if (clockEnable && push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (clockEnable) begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sample_fifo
`default_nettype wire

// ==== verilog/overrange_hold.sv ====
`timescale 1ns/100ps
`default_nettype none
module overrange_hold
  import ovr_stamp_pkg::*;
(
  // Clocking
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clockEnable,
  // Sample and settings
  input wire sample_t sample,
  input wire ovr_cfg_s cfg,
  // Status
  output logic eventHit,
  output logic overrange
);
  logic [HOLD_W-1:0] holdCount;

  // Negative full scale has no positive twin, so it saturates
  function automatic logic [MAG_W-1:0] magnitude(input sample_t s);
    logic [SAMPLE_W-1:0] neg;
    neg = SAMPLE_W'(-s);
    if (!s[SAMPLE_W-1]) begin
      magnitude = s[MAG_W-1:0];
    end else if (neg[SAMPLE_W-1]) begin
      magnitude = MAG_MAX;
    end else begin
      magnitude = neg[MAG_W-1:0];
    end
  endfunction

  assign eventHit = cfg.enable && (magnitude(sample) >= cfg.threshold); // RULE3 RULE4 RULE5

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      holdCount <= '0;
      overrange <= 1'b0;
    end else if (clockEnable) begin
      if (!cfg.enable) begin
        holdCount <= '0; // RULE17
        overrange <= 1'b0; // RULE17
      end else if (eventHit) begin
        holdCount <= HOLD_BASE << cfg.holdSelect; // RULE8
        overrange <= 1'b1; // RULE6
      end else if (holdCount > HOLD_W'(1)) begin
        holdCount <= holdCount - 1'b1;
      end else begin
        holdCount <= '0;
        overrange <= 1'b0; // RULE6
      end
    end
  end
endmodule // overrange_hold
`default_nettype wire

// ==== test/ovr_stamp_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module ovr_stamp_monitor
  import ovr_stamp_pkg::*;
(
  // Clocking
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clockEnable,
  // Inputs
  input wire sample_set_s samples,
  input wire logic stamp_input_pair,
  input wire logic overrange_detect_enable,
  input wire logic [MAG_W-1:0] overrange_threshold,
  input wire logic stamp_receiver_enable,
  input wire logic trigger_repeat_enable,
  input wire logic [1:0] trigger_repeat_select,
  input wire logic [1:0] link_format_select,
  // Outputs
  input wire logic overrange_out_a,
  input wire logic overrange_out_b,
  input wire logic overrange_out_c,
  input wire logic overrange_out_d,
  input wire logic trigger_repeat_out,
  input wire logic linkValid,
  input wire link_frame_s linkFrame,
  input wire logic sampleReady
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // Lowest code has no positive twin, so it clamps
  function automatic logic [MAG_W-1:0] mag(sample_t s);
    return (s == 9'h100) ? MAG_MAX : (s[8] ? MAG_W'(-s) : s[MAG_W-1:0]);
  endfunction
  property p_off;
    (!overrange_detect_enable && clockEnable)[*2] |=>
      {overrange_out_d, overrange_out_c, overrange_out_b, overrange_out_a} == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("pin high while off");
  property p_gate;
    $rose(overrange_out_a) |-> $past(overrange_detect_enable);
  endproperty
  a_gate: assert property (p_gate) else $error("pin rose while off");
  property p_magA;
    $rose(overrange_out_a) |-> mag($past(samples.ch[0], 3)) >= $past(overrange_threshold, 2);
  endproperty
  a_magA: assert property (p_magA) else $error("pin a without cause");
  property p_magB;
    $rose(overrange_out_b) |-> mag($past(samples.ch[1], 3)) >= $past(overrange_threshold, 2);
  endproperty
  a_magB: assert property (p_magB) else $error("pin b without cause");
  property p_hold;
    $rose(overrange_out_c) |-> overrange_out_c[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("pin pulse short");
  property p_trig;
    trigger_repeat_out |-> $past(trigger_repeat_enable && stamp_receiver_enable
      && trigger_repeat_select == TRIG_MODE_STAMP);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not gated");
  property p_trigLag;
    $rose(trigger_repeat_out) |-> $past(stamp_input_pair, 3);
  endproperty
  a_trigLag: assert property (p_trigLag) else $error("trigger lag wrong");
  property p_mode0;
    linkValid && link_format_select == 2'h0 |-> linkFrame.word[0][2:1] == 2'h0
      && linkFrame.word[0][N16_MSB:N12_MSB+1] == 4'h0;
  endproperty
  a_mode0: assert property (p_mode0) else $error("word layout wrong");
  c_hold: cover property ($rose(overrange_out_a));
  c_trig: cover property ($rose(trigger_repeat_out));
  c_full: cover property (!sampleReady);
endmodule // ovr_stamp_monitor
bind overrange_and_timestamp_marker ovr_stamp_monitor u_monitor (.*);
`default_nettype wire

// ==== test/link_sink_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module link_sink_model
  import ovr_stamp_pkg::*;
(
  // Clocking
  input wire logic ref_clk,
  input wire logic reset_n,
  // Stream
  input wire logic linkValid,
  input wire link_frame_s linkFrame,
  output logic linkReady,
  // Bench stall and flags
  input wire logic stall,
  input wire logic [CHANNELS-1:0] flags,
  output logic gainLow
);
  link_frame_s got[$];
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      linkReady <= 1'b0;
      gainLow <= 1'b0;
    end else begin
      if (linkValid && linkReady) begin
        got.push_back(linkFrame);
      end
      // Ready lags a stall by one edge, as real backpressure does
      linkReady <= !stall;
      gainLow <= |flags;
    end
  end
endmodule // link_sink_model
`default_nettype wire

// ==== test/overrange_and_timestamp_marker_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module overrange_and_timestamp_marker_tb_top;
  import ovr_stamp_pkg::*;
  logic ref_clk = 1'b0, reset_n = 1'b0, clockEnable = 1'b1, stall = 1'b0;
  logic sampleValid = 1'b0, stamp_input_pair = 1'b0, statusClear = 1'b0;
  logic overrange_detect_enable = 1'b1, stampInsertEnable = 1'b0;
  logic stamp_receiver_enable = 1'b1, trigger_repeat_enable = 1'b1;
  logic [SEL_W-1:0] overrange_hold_select = 3'h0;
  logic [MAG_W-1:0] overrange_threshold = THRESHOLD_RESET;
  logic [1:0] trigger_repeat_select = 2'h0, link_format_select = 2'h0;
  sample_set_s samples = '0;
  logic sampleReady, trigger_repeat_out, linkValid, linkReady, sampleDropped, gainLow;
  logic overrange_out_a, overrange_out_b, overrange_out_c, overrange_out_d;
  logic [CHANNELS-1:0] overrangeSeen, pins;
  logic [STAMP_CNT_W-1:0] stampCount;
  link_frame_s linkFrame;
  int mismatches = 0, checkCount = 0, cycles = 0;
  assign pins = {overrange_out_d, overrange_out_c, overrange_out_b, overrange_out_a};
  overrange_and_timestamp_marker dut (.*);
  link_sink_model sink (.ref_clk, .reset_n, .linkValid, .linkFrame, .linkReady, .stall,
    .flags(pins), .gainLow);
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checkCount++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic results();
    if (mismatches == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic drive(input sample_set_s v, input logic st);
    samples <= v;
    sampleValid <= 1'b1;
    stamp_input_pair <= st;
    tick(1);
  endtask
  task automatic idle();
    samples <= '0;
    sampleValid <= 1'b0;
    stamp_input_pair <= 1'b0;
  endtask
  task automatic mag_case(input sample_t v, input logic [MAG_W-1:0] th, input logic hit);
    overrange_threshold <= th;
    drive({4{v}}, 1'b0);
    idle();
    tick(4);
    check("pins", {4{hit}}, pins);
    check("seen", {4{hit}}, overrangeSeen);
    check("gain", hit, gainLow);
    statusClear <= 1'b1;
    tick(12);
    statusClear <= 1'b0;
  endtask
  task automatic hold_len();
    int n;
    overrange_threshold <= 8'hff;
    for (int s = 0; s < 8; s++) begin
      overrange_hold_select <= 3'(s);
      n = 0;
      drive({4{9'h0ff}}, 1'b0);
      idle();
      repeat (1040) begin
        tick(1);
        n += int'(overrange_out_a === 1'b1);
      end
      check("hold", 64'(HOLD_BASE) << s, 64'(n));
    end
  endtask
  task automatic disable_run();
    overrange_hold_select <= 3'h7;
    drive({4{9'h0ff}}, 1'b0);
    idle();
    tick(12);
    check("held", 4'hf, pins);
    overrange_detect_enable <= 1'b0;
    tick(3);
    check("off", 4'h0, pins);
    drive({4{9'h100}}, 1'b0);
    idle();
    tick(4);
    check("gated", 4'h0, pins);
    overrange_detect_enable <= 1'b1;
    overrange_hold_select <= 3'h0;
    tick(3);
    check("cleared", 4'h0, pins);
  endtask
  // Frozen clock enable must stretch the pulse past its hold length
  task automatic freeze_run();
    overrange_hold_select <= 3'h0;
    drive({4{9'h0ff}}, 1'b0);
    idle();
    tick(3);
    clockEnable <= 1'b0;
    tick(20);
    check("frozen", 4'hf, pins);
    clockEnable <= 1'b1;
    tick(12);
    check("thawed", 4'h0, pins);
  endtask
  task automatic link_modes();
    link_word_t w;
    for (int m = 1; m < 3; m++) begin
      link_format_select <= 2'(m);
      tick(2);
      sink.got.delete();
      drive({4{9'h1a5}}, 1'b0);
      idle();
      tick(8);
      if (m == 1) begin
        w = 16'h00d2;
      end else begin
        w = {9'h1a5, 7'h00};
      end
      check("modeWord", {4{w}}, sink.got[0]);
    end
    link_format_select <= 2'h0;
    tick(2);
  endtask
  task automatic trig_modes();
    logic hit;
    for (int m = 0; m < 4; m++) begin
      trigger_repeat_select <= 2'(m);
      tick(2);
      hit = 1'b0;
      drive('0, 1'b1);
      idle();
      repeat (6) begin
        tick(1);
        hit |= trigger_repeat_out;
      end
      check("trig", 64'(m == 3), 64'(hit));
    end
    check("stamps", 16'h0004, stampCount);
  endtask
  task automatic stamp_link();
    sample_t vals[3] = '{9'h1fd, 9'h0a5, 9'h013};
    link_word_t w;
    for (int ins = 0; ins < 2; ins++) begin
      stampInsertEnable <= 1'(ins);
      tick(2);
      sink.got.delete();
      for (int i = 0; i < 3; i++) begin
        drive({4{vals[i]}}, i == 1);
      end
      idle();
      tick(10);
      check("count", 64'd3, 64'(sink.got.size()));
      for (int i = 0; i < 3; i++) begin
        w = {4'h0, vals[i], 2'h0, 1'(ins == 1 && i == 1)};
        check("word", {4{w}}, sink.got[i]);
      end
    end
  endtask
  task automatic fifo_full();
    stall <= 1'b1;
    tick(3);
    sink.got.delete();
    for (int i = 0; i < 40; i++) begin
      drive({4{9'(i)}}, 1'b0);
    end
    idle();
    tick(4);
    check("ready", 64'd0, sampleReady);
    check("drop", 64'd1, sampleDropped);
    stall <= 1'b0;
    tick(60);
    check("drained", 64'(FIFO_DEPTH), 64'(sink.got.size()));
    check("last", {4{16'h00f8}}, sink.got[31]);
    statusClear <= 1'b1;
    tick(2);
    statusClear <= 1'b0;
    check("dropClr", 64'd0, sampleDropped);
  endtask
  initial begin
    tick(12);
    reset_n <= 1'b1;
    tick(2);
    mag_case(9'h0ff, 8'hff, 1'b1);
    mag_case(9'h100, 8'hff, 1'b1);
    mag_case(9'h0fe, 8'hff, 1'b0);
    mag_case(9'h102, 8'hfe, 1'b1);
    mag_case(9'h000, 8'h01, 1'b0);
    mag_case(9'h000, 8'h00, 1'b1);
    mag_case(9'h11c, THRESHOLD_RESET, 1'b1);
    mag_case(9'h0e3, THRESHOLD_RESET, 1'b0);
    hold_len();
    disable_run();
    freeze_run();
    trig_modes();
    stamp_link();
    link_modes();
    fifo_full();
    results();
  end
endmodule // overrange_and_timestamp_marker_tb_top
`default_nettype wire
